// file: logic/ast_pkg.sv
// Shared constants, field positions and decode helper for the status bank
package ast_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [15:0] OFS_ACQ_CTRL = 16'h8100;
  localparam logic [15:0] OFS_RUN_STATE_FLAGS = 16'h8104;
  localparam logic [15:0] OFS_SOFT_TRIGGER_STROBE = 16'h8108;
  localparam logic [15:0] OFS_TRIGGER_SOURCE_MASK = 16'h810C;
  localparam logic [15:0] OFS_OUTPUT_PULSE_SOURCE_MASK = 16'h8110;
  localparam logic [15:0] OFS_LOCK_FLAG_RESTORE = 16'hEF04;

  // Status word bit positions
  localparam int ST_RUNNING = 2;
  localparam int ST_EVT_READY = 3;
  localparam int ST_EVT_FULL = 4;
  localparam int ST_CLK_EXT = 5;
  localparam int ST_LOCK_OK = 7;
  localparam int ST_BOARD_READY = 8;
  localparam int ST_GPI = 15;
  localparam int ST_EXT_TRIG = 16;

  // Acquisition control field positions
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_ARM = 2;
  localparam int CTL_CLK_EXT = 6;

  // Mask fields: bit 29 lvds, 30 external, 31 software
  localparam int MASK_LSB = 29;
  localparam int MASK_LVDS = 0;
  localparam int MASK_EXT = 1;
  localparam int MASK_SW = 2;

  // Byte lanes that hold the stored fields
  localparam int BE_CTRL = 0;
  localparam int BE_MASK = 3;

  typedef enum logic [1:0] {
    RUN_SW,
    RUN_GPI,
    RUN_FIRST_TRIG,
    RUN_LVDS
  } ast_run_mode_type;

  // Reset values
  localparam ast_run_mode_type MODE_RST = RUN_SW;
  localparam logic ARM_RST = 1'b0;
  localparam logic CLK_EXT_RST = 1'b0;
  localparam logic [2:0] GMASK_RST = 3'b110;
  localparam logic [2:0] OMASK_RST = 3'b000;
  localparam logic LOCK_OK_RST = 1'b1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  function automatic logic ast_hit(input logic [15:0] a,
                                   input logic [15:0] o);
    ast_hit = (a == o);
  endfunction : ast_hit

endpackage : ast_pkg

// file: logic/ast_reg_if.sv
// Carrier between the bus front end and the register core
`timescale 1ns/1ps
interface ast_reg_if;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] rdata;

  modport bus (
    output addr, wdata, be, wr_stb, rd_stb,
    input rdata
  );
  modport core (
    input addr, wdata, be, wr_stb, rd_stb,
    output rdata
  );
endinterface : ast_reg_if

// file: logic/ast_avs_slave.sv
// Avalon-MM slave front end: one wait cycle, registered read data
`timescale 1ns/1ps
module ast_avs_slave (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [ast_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ast_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [ast_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Register core side
  ast_reg_if.bus rif
);
  import ast_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } ast_fe_state_type;

  ast_fe_state_type s_ff;
  ast_fe_state_type nxt_s;
  logic req;

  assign req = avs_read_i | avs_write_i;
  // Waitrequest drops for exactly the second cycle of each request
  assign avs_waitrequest_o = req & ~s_ff.ack;
  assign avs_readdata_o = s_ff.rdata;
  assign rif.addr = avs_address_i;
  assign rif.wdata = avs_writedata_i;
  assign rif.be = avs_byteenable_i;
  assign rif.wr_stb = avs_write_i & s_ff.ack;
  assign rif.rd_stb = avs_read_i & s_ff.ack;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.ack = req & ~s_ff.ack;
    // Data captured a cycle early so they stand at the accepting edge
    if (avs_read_i && !s_ff.ack) begin
      nxt_s.rdata = rif.rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_ff <= '{ack: 1'b0, rdata: ZERO_WORD};
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule : ast_avs_slave

// file: logic/ast_status_bank.sv
// Acquisition status, software trigger and trigger routing register bank
//
// Overview of operation
// - Status bit 2 shows running; drives lamp
// - Status bit 3 shows event ready
// - Status bit 4 shows channel full
// - Status bit 5 shows external PLL reference
// - Status bit 7 low after any unlock
// - Reading 0xEF04 restores lock flag to one
// - Status bit 8 shows PLL and ADCs synced
// - Status bit 15 shows general purpose input
// - Status bit 16 shows external trigger input
// - Any write to 0x8108 fires software trigger
// - Global mask bit 29 gates LVDS trigger
// - Global mask bit 30 gates external trigger
// - Global mask bit 31 gates software trigger
// - Output mask bit 29 gates LVDS when output
// - Output mask bit 30 gates external trigger
// - Output mask bit 31 gates software trigger
// - Mode 00: arm bit starts and stops run
`timescale 1ns/1ps
module ast_status_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [ast_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ast_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [ast_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Readout and clocking status
  input wire logic evt_ready_i,
  input wire logic evt_full_i,
  input wire logic pll_locked_i,
  input wire logic adc_sync_i,
  // Front panel and LVDS inputs
  input wire logic general_purpose_input_i,
  input wire logic external_trigger_input_i,
  input wire logic lvds_trigger_i,
  input wire logic lvds_as_output_i,
  input wire logic lvds_run_i,
  // Outputs
  output logic run_lamp_o,
  output logic pll_ref_ext_o,
  output logic sw_trigger_o,
  output logic global_trigger_o,
  output logic trigger_output_o
);
  import ast_pkg::*;

  typedef struct packed {
    ast_run_mode_type mode;
    logic arm;
    logic clk_ext;
    logic [2:0] gmask;
    logic [2:0] omask;
    logic running;
    logic lock_ok;
    logic sw_pulse;
    logic ext_prev;
    logic gtrig;
    logic otrig;
  } ast_core_state_type;

  localparam ast_core_state_type CORE_RST = '{
    mode: MODE_RST,
    arm: ARM_RST,
    clk_ext: CLK_EXT_RST,
    gmask: GMASK_RST,
    omask: OMASK_RST,
    running: 1'b0,
    lock_ok: LOCK_OK_RST,
    sw_pulse: 1'b0,
    ext_prev: 1'b0,
    gtrig: 1'b0,
    otrig: 1'b0
  };

  ast_core_state_type s_ff;
  ast_core_state_type nxt_s;
  ast_reg_if rif ();

  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] gmask_word;
  logic [31:0] omask_word;
  logic board_ready;
  logic ext_rise;
  logic ext_blocked;
  logic [2:0] gsrc;
  logic [2:0] osrc;
  logic wr_ctrl;
  logic wr_gmask;
  logic wr_omask;
  logic wr_swtrig;
  logic rd_restore;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end

  ast_avs_slave u_slave (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .rif(rif.bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode and read mux

  assign wr_ctrl = rif.wr_stb & ast_hit(rif.addr, OFS_ACQ_CTRL)
                   & rif.be[BE_CTRL];
  assign wr_gmask = rif.wr_stb & ast_hit(rif.addr, OFS_TRIGGER_SOURCE_MASK)
                    & rif.be[BE_MASK];
  assign wr_omask = rif.wr_stb
                    & ast_hit(rif.addr, OFS_OUTPUT_PULSE_SOURCE_MASK)
                    & rif.be[BE_MASK];
  // Data and byte lanes are ignored: any write counts
  assign wr_swtrig = rif.wr_stb & ast_hit(rif.addr, OFS_SOFT_TRIGGER_STROBE);
  assign rd_restore = rif.rd_stb & ast_hit(rif.addr, OFS_LOCK_FLAG_RESTORE);

  assign board_ready = pll_locked_i & adc_sync_i;

  always_comb begin
    status_word = ZERO_WORD;
    status_word[ST_RUNNING] = s_ff.running;
    status_word[ST_EVT_READY] = evt_ready_i;
    status_word[ST_EVT_FULL] = evt_full_i;
    status_word[ST_CLK_EXT] = s_ff.clk_ext;
    status_word[ST_LOCK_OK] = s_ff.lock_ok;
    status_word[ST_BOARD_READY] = board_ready;
    status_word[ST_GPI] = general_purpose_input_i;
    status_word[ST_EXT_TRIG] = external_trigger_input_i;
  end

  always_comb begin
    ctrl_word = ZERO_WORD;
    ctrl_word[CTL_MODE_LSB +: 2] = s_ff.mode;
    ctrl_word[CTL_ARM] = s_ff.arm;
    ctrl_word[CTL_CLK_EXT] = s_ff.clk_ext;
    gmask_word = ZERO_WORD;
    gmask_word[MASK_LSB +: 3] = s_ff.gmask;
    omask_word = ZERO_WORD;
    omask_word[MASK_LSB +: 3] = s_ff.omask;
  end

  // Write-only strobe, restore address and unmapped space read as zero
  always_comb begin
    unique case (rif.addr)
      OFS_ACQ_CTRL: rif.rdata = ctrl_word;
      OFS_RUN_STATE_FLAGS: rif.rdata = status_word;
      OFS_TRIGGER_SOURCE_MASK: rif.rdata = gmask_word;
      OFS_OUTPUT_PULSE_SOURCE_MASK: rif.rdata = omask_word;
      default: rif.rdata = ZERO_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control and trigger routing

  assign ext_rise = external_trigger_input_i & ~s_ff.ext_prev;
  // The edge that starts a first-trigger run is not a global trigger itself; the output mask path still passes it
  assign ext_blocked = (s_ff.mode == RUN_FIRST_TRIG) & s_ff.arm
                       & ~s_ff.running;
  assign gsrc = {s_ff.sw_pulse,
                 external_trigger_input_i & ~ext_blocked,
                 lvds_trigger_i};
  assign osrc = {s_ff.sw_pulse,
                 external_trigger_input_i,
                 lvds_trigger_i & lvds_as_output_i};

  always_comb begin
    nxt_s = s_ff;
    nxt_s.ext_prev = external_trigger_input_i;
    // Only the stored fields take write data
    if (wr_ctrl) begin
      nxt_s.mode = ast_run_mode_type'(rif.wdata[CTL_MODE_LSB +: 2]);
      nxt_s.arm = rif.wdata[CTL_ARM];
      nxt_s.clk_ext = rif.wdata[CTL_CLK_EXT];
    end
    if (wr_gmask) begin
      nxt_s.gmask = rif.wdata[MASK_LSB +: 3];
    end
    if (wr_omask) begin
      nxt_s.omask = rif.wdata[MASK_LSB +: 3];
    end
    nxt_s.sw_pulse = wr_swtrig;
    // An unlock in the cycle of the restoring read still wins
    if (!pll_locked_i) begin
      nxt_s.lock_ok = 1'b0;
    end else if (rd_restore) begin
      nxt_s.lock_ok = 1'b1;
    end
    unique case (s_ff.mode)
      RUN_SW: nxt_s.running = s_ff.arm;
      RUN_GPI: nxt_s.running = s_ff.arm & general_purpose_input_i;
      RUN_FIRST_TRIG: nxt_s.running = s_ff.arm & (s_ff.running | ext_rise);
      RUN_LVDS: nxt_s.running = s_ff.arm & lvds_run_i;
    endcase
    nxt_s.gtrig = |(s_ff.gmask & gsrc);
    nxt_s.otrig = |(s_ff.omask & osrc);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_ff <= CORE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Lamp follows the same flop that software reads
  assign run_lamp_o = s_ff.running;
  assign pll_ref_ext_o = s_ff.clk_ext;
  assign sw_trigger_o = s_ff.sw_pulse;
  assign global_trigger_o = s_ff.gtrig;
  assign trigger_output_o = s_ff.otrig;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_strobe_write;
    rif.wr_stb && rif.addr == OFS_SOFT_TRIGGER_STROBE;
  endsequence

  sequence s_single_pulse;
    sw_trigger_o ##1 !sw_trigger_o;
  endsequence

  property p_run_mode_sw;
    s_ff.mode == RUN_SW |=> run_lamp_o == $past(s_ff.arm);
  endproperty
  a_run_mode_sw: assert property (p_run_mode_sw)
    else $error("running does not follow arm in software mode");

  property p_lamp_status;
    rif.addr == OFS_RUN_STATE_FLAGS
      |-> rif.rdata[ST_RUNNING] == run_lamp_o;
  endproperty
  a_lamp_status: assert property (p_lamp_status)
    else $error("running bit and lamp disagree");

  property p_readout_bits;
    rif.addr == OFS_RUN_STATE_FLAGS
      |-> rif.rdata[ST_EVT_READY] == evt_ready_i
          && rif.rdata[ST_EVT_FULL] == evt_full_i;
  endproperty
  a_readout_bits: assert property (p_readout_bits)
    else $error("event ready or full bit wrong");

  property p_clk_ref;
    rif.addr == OFS_RUN_STATE_FLAGS
      |-> rif.rdata[ST_CLK_EXT] == pll_ref_ext_o;
  endproperty
  a_clk_ref: assert property (p_clk_ref)
    else $error("clock source bit disagrees with reference select");

  property p_unlock_sticky;
    !pll_locked_i |=> !s_ff.lock_ok ##1 (!s_ff.lock_ok || $past(rd_restore));
  endproperty
  a_unlock_sticky: assert property (p_unlock_sticky)
    else $error("lock flag not held low after unlock");

  property p_restore;
    rd_restore && pll_locked_i |=> s_ff.lock_ok;
  endproperty
  a_restore: assert property (p_restore)
    else $error("restoring read did not set lock flag");

  property p_board_ready;
    rif.addr == OFS_RUN_STATE_FLAGS
      |-> rif.rdata[ST_BOARD_READY] == (pll_locked_i && adc_sync_i);
  endproperty
  a_board_ready: assert property (p_board_ready)
    else $error("board ready bit wrong");

  property p_pins;
    rif.addr == OFS_RUN_STATE_FLAGS
      |-> rif.rdata[ST_GPI] == general_purpose_input_i
          && rif.rdata[ST_EXT_TRIG] == external_trigger_input_i;
  endproperty
  a_pins: assert property (p_pins)
    else $error("front panel level bits wrong");

  property p_sw_trigger;
    s_strobe_write |=> s_single_pulse;
  endproperty
  a_sw_trigger: assert property (p_sw_trigger)
    else $error("software trigger write gave no single pulse");

  property p_global_sw;
    sw_trigger_o && s_ff.gmask[MASK_SW] |=> global_trigger_o;
  endproperty
  a_global_sw: assert property (p_global_sw)
    else $error("enabled software trigger missing on global trigger");

  property p_global_off;
    s_ff.gmask == 3'b000 |=> !global_trigger_o;
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("global trigger fired with all sources masked");

  property p_global_lvds;
    lvds_trigger_i && s_ff.gmask[MASK_LVDS] |=> global_trigger_o;
  endproperty
  a_global_lvds: assert property (p_global_lvds)
    else $error("enabled lvds trigger missing on global trigger");

  property p_out_ext;
    external_trigger_input_i && s_ff.omask[MASK_EXT] |=> trigger_output_o;
  endproperty
  a_out_ext: assert property (p_out_ext)
    else $error("enabled external trigger missing on trigger output");

  property p_out_lvds_dir;
    s_ff.omask == 3'b001 && !lvds_as_output_i |=> !trigger_output_o;
  endproperty
  a_out_lvds_dir: assert property (p_out_lvds_dir)
    else $error("lvds reached trigger output while an input");

  property p_out_sw;
    s_strobe_write ##1 s_ff.omask[MASK_SW] |=> trigger_output_o;
  endproperty
  a_out_sw: assert property (p_out_sw)
    else $error("enabled software trigger missing on trigger output");

  property p_mask_reserved;
    rif.addr == OFS_TRIGGER_SOURCE_MASK
      |-> rif.rdata[MASK_LSB-1:0] == '0;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved)
    else $error("reserved mask bits not zero");

  property p_status_reserved;
    rif.addr == OFS_RUN_STATE_FLAGS
      |-> rif.rdata[1:0] == 2'b00 && rif.rdata[31:17] == '0
          && rif.rdata[14:9] == '0 && rif.rdata[6] == 1'b0;
  endproperty
  a_status_reserved: assert property (p_status_reserved)
    else $error("reserved status bits not zero");

endmodule : ast_status_bank

// file: bench/ast_host_model.sv
// Host software model: Avalon-MM master for the status bank
`timescale 1ns/1ps
module ast_host_model (
  // Clock
  input wire logic clk_i,
  // Avalon-MM master
  output logic [15:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  initial begin
    avs_address_o = 16'h0000;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0000_0000;
    avs_byteenable_o = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One access; the leading edge keeps back-to-back calls from
  // assigning the strobe twice in one time step
  task automatic xfer(input logic wr, input logic [15:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_byteenable_o <= be;
    avs_read_o <= !wr;
    avs_write_o <= wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_i !== 1'b0 && n < 50);
    q = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    // Released address and data lines must not keep showing the old value; byte enables keep it
    avs_address_o <= ~a;
    avs_writedata_o <= ~d;
    if (n >= 50) begin
      testbench.err_count++;
      testbench.finish_test();
    end
  endtask : xfer
endmodule : ast_host_model

// file: bench/testbench.sv
// Self-checking bench for the status and trigger routing bank
`timescale 1ns/1ps
module testbench;
  import ast_pkg::*;
  logic clk_i, reset_i, rd, wr, wait_r;
  logic [15:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] be;
  logic evt, full, pll, adc, general_purpose_input, ext, lvt, lvo, lvr;
  logic lamp, refx, swt, gtr, tout;
  logic [2:0] g, o;
  int err_count, check_count, i, n;

  ast_status_bank ast_status_bank_i (
    .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_r), .evt_ready_i(evt), .evt_full_i(full),
    .pll_locked_i(pll), .adc_sync_i(adc),
    .general_purpose_input_i(general_purpose_input), .external_trigger_input_i(ext),
    .lvds_trigger_i(lvt), .lvds_as_output_i(lvo), .lvds_run_i(lvr),
    .run_lamp_o(lamp), .pll_ref_ext_o(refx), .sw_trigger_o(swt),
    .global_trigger_o(gtr), .trigger_output_o(tout)
  );

  ast_host_model ast_host_model_i (
    .clk_i(clk_i), .avs_address_o(adr), .avs_read_o(rd),
    .avs_write_o(wr), .avs_writedata_o(wdat), .avs_byteenable_o(be),
    .avs_readdata_i(rdat), .avs_waitrequest_i(wait_r)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input logic [15:0] a, input logic [31:0] d,
                   input logic [3:0] b);
    logic [31:0] x;
    ast_host_model_i.xfer(1'b1, a, d, b, x);
  endtask : w

  task automatic r(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] x;
    ast_host_model_i.xfer(1'b0, a, 32'h0000_0000, 4'hF, x);
    chk(x, e);
  endtask : r

  // Expected status word from the present input levels
  function automatic logic [31:0] st(input logic run, input logic cx,
                                     input logic lk);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[ST_RUNNING] = run;
    v[ST_EVT_READY] = evt;
    v[ST_EVT_FULL] = full;
    v[ST_CLK_EXT] = cx;
    v[ST_LOCK_OK] = lk;
    v[ST_BOARD_READY] = pll & adc;
    v[ST_GPI] = general_purpose_input;
    v[ST_EXT_TRIG] = ext;
    return v;
  endfunction : st

  task automatic finish_test;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    check_count = 0;
    reset_i = 1'b1;
    {evt, full, general_purpose_input, ext, lvt, lvo, lvr} = 7'h00;
    pll = 1'b1;
    adc = 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    n = 0;
    do begin
      ast_host_model_i.xfer(1'b0, OFS_RUN_STATE_FLAGS, 32'h0, 4'hF,
                            q);
      n++;
    end while (q[ST_BOARD_READY] !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      finish_test();
    end
    r(OFS_TRIGGER_SOURCE_MASK, 32'hC000_0000);
    r(OFS_OUTPUT_PULSE_SOURCE_MASK, 32'h0000_0000);
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b1));
    for (i = 0; i < 6; i++) begin
      @(posedge clk_i);
      evt <= (i == 0);
      full <= (i == 1);
      general_purpose_input <= (i == 2);
      ext <= (i == 3);
      adc <= (i != 4);
      @(posedge clk_i);
      r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b1));
      chk(32'(gtr), 32'(i == 3));
    end
    // A single-cycle unlock must be remembered until the restore read
    @(posedge clk_i);
    pll <= 1'b0;
    @(posedge clk_i);
    pll <= 1'b1;
    @(posedge clk_i);
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b0));
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b0));
    r(OFS_LOCK_FLAG_RESTORE, 32'h0000_0000);
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b1));
    w(OFS_ACQ_CTRL, 32'h0000_0044, 4'h1);
    r(OFS_RUN_STATE_FLAGS, st(1'b1, 1'b1, 1'b1));
    chk(32'({lamp, refx}), 32'h0000_0003);
    r(OFS_ACQ_CTRL, 32'h0000_0044);
    w(OFS_ACQ_CTRL, 32'h0000_0000, 4'hE);
    r(OFS_ACQ_CTRL, 32'h0000_0044);
    w(OFS_ACQ_CTRL, 32'h0000_0000, 4'h1);
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b1));
    chk(32'({lamp, refx}), 32'h0000_0000);
    w(OFS_TRIGGER_SOURCE_MASK, 32'hFFFF_FFFF, 4'hF);
    r(OFS_TRIGGER_SOURCE_MASK, 32'hE000_0000);
    w(OFS_TRIGGER_SOURCE_MASK, 32'h0000_0000, 4'h7);
    r(OFS_TRIGGER_SOURCE_MASK, 32'hE000_0000);
    w(OFS_RUN_STATE_FLAGS, 32'hFFFF_FFFF, 4'hF);
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b1));
    r(16'h8200, 32'h0000_0000);
    r(OFS_SOFT_TRIGGER_STROBE, 32'h0000_0000);
    // Every mask combination, output mask the complement of global
    for (i = 0; i < 8; i++) begin
      g = 3'(i);
      o = ~g;
      w(OFS_TRIGGER_SOURCE_MASK, {g, 29'h0000_0000}, 4'hF);
      w(OFS_OUTPUT_PULSE_SOURCE_MASK, {o, 29'h0000_0000}, 4'hF);
      w(OFS_SOFT_TRIGGER_STROBE, 32'h1234_5678 ^ 32'(i), 4'h0);
      #1;
      chk(32'({swt, gtr, tout}), 32'h0000_0004);
      @(posedge clk_i);
      #1;
      chk(32'({swt, gtr, tout}), 32'({1'b0, g[2], o[2]}));
      @(posedge clk_i);
      ext <= 1'b1;
      @(posedge clk_i);
      #1;
      chk(32'({gtr, tout}), 32'({g[1], o[1]}));
      @(posedge clk_i);
      ext <= 1'b0;
      @(posedge clk_i);
      lvt <= 1'b1;
      // Direction varies apart from the masks so both gated cases occur
      lvo <= i[1] ^ i[2];
      @(posedge clk_i);
      #1;
      chk(32'({gtr, tout}), 32'({g[0], o[0] & (i[1] ^ i[2])}));
      @(posedge clk_i);
      lvt <= 1'b0;
      lvo <= 1'b0;
    end
    // Gated start modes: input level, first external edge, lvds level
    w(OFS_ACQ_CTRL, 32'h0000_0005, 4'h1);
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b1));
    general_purpose_input <= 1'b1;
    @(posedge clk_i);
    r(OFS_RUN_STATE_FLAGS, st(1'b1, 1'b0, 1'b1));
    general_purpose_input <= 1'b0;
    @(posedge clk_i);
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b1));
    w(OFS_ACQ_CTRL, 32'h0000_0006, 4'h1);
    ext <= 1'b1;
    @(posedge clk_i);
    #1;
    // The starting edge is swallowed, later levels trigger
    chk(32'({lamp, gtr}), 32'h0000_0002);
    @(posedge clk_i);
    #1;
    chk(32'(gtr), 32'h0000_0001);
    @(posedge clk_i);
    ext <= 1'b0;
    @(posedge clk_i);
    r(OFS_RUN_STATE_FLAGS, st(1'b1, 1'b0, 1'b1));
    w(OFS_ACQ_CTRL, 32'h0000_0007, 4'h1);
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b1));
    lvr <= 1'b1;
    @(posedge clk_i);
    r(OFS_RUN_STATE_FLAGS, st(1'b1, 1'b0, 1'b1));
    w(OFS_ACQ_CTRL, 32'h0000_0003, 4'h1);
    r(OFS_RUN_STATE_FLAGS, st(1'b0, 1'b0, 1'b1));
    lvr <= 1'b0;
    finish_test();
  end
endmodule : testbench
